// File: hw/mlrc_top.sv
// reset sequencing, mac configuration writer and receive-to-transmit loopback
`timescale 1ns/10ps
// Function
// - mac runs 10GBASE-R with a 32-bit datapath toward the lane.
// - mac user-side packet interface is 64 bits wide.
// - pause disabled; mac internal fifos hold 256 entries each.
// - controller is the only apb master toward the mac slave.
// - every received frame passes through a fifo to the transmit side.
// - lane uses 64b/66b, self-synchronising scrambler, 10312.5 Mbps.
// - controller and loopback held in reset until base release and rx ready.
// - mac rx reset held until base release and lane receive valid.
// - mac tx reset held until power-init done and lane tx clock stable.
// - lane pcs async reset driven from mac tx sync reset output.
// - conditioner gives 50 MHz configuration and 156.25 MHz user clocks.
// - all integration logic runs in one clock domain.
// - power-up: power-on reset, boot, then initialization loading lane settings.
// - looped frames go to mac transmit, then out the lane.
module mlrc_top
   import mlrc_pkg::*;
#(
   parameter int SYS_WIDTH = MLRC_SYS_WIDTH,
   parameter int LOOP_DEPTH = MLRC_LOOP_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // power-up and clocking status (pins)
   input wire logic power_init_done,
   input wire logic pll_lock,
   // transceiver lane status (pins)
   input wire logic lane_receive_valid,
   input wire logic lane_transmit_clock_stable,
   // mac status
   input wire logic mac_rx_ready,
   input wire logic mac_transmit_sync_reset,
   // reset outputs
   output logic mac_rx_reset_b,
   output logic mac_tx_reset_b,
   output logic lane_pcs_async_reset_n,
   output logic ctrl_reset_b,
   // mac and lane static configuration
   output logic mac_mode_baser,
   output logic [7:0] mac_core_width,
   output logic mac_pause_en,
   output logic [8:0] mac_fifo_depth,
   output logic lane_mode_64b66b,
   output logic lane_scramble_en,
   // apb master toward the mac
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // configuration status
   output logic cfg_done,
   output logic cfg_error,
   // mac receive packet interface
   input wire logic rx_valid,
   input wire logic [SYS_WIDTH-1:0] rx_data,
   input wire logic rx_sop,
   input wire logic rx_eop,
   input wire logic [MLRC_BYTE_COUNT_W-1:0] rx_byte_valid,
   output logic rx_ready,
   // mac transmit packet interface
   output logic tx_valid,
   output logic [SYS_WIDTH-1:0] tx_data,
   output logic tx_sop,
   output logic tx_eop,
   output logic [MLRC_BYTE_COUNT_W-1:0] tx_byte_valid,
   input wire logic tx_ready
);
   typedef enum logic [2:0] {
      ST_WAIT, ST_TX_SETUP, ST_TX_ACCESS, ST_RX_SETUP, ST_RX_ACCESS, ST_DONE
   } mlrc_cfg_state_type;

   // pin synchronisers
   logic [1:0] pinit_s_r;
   logic [1:0] lock_s_r;
   logic [1:0] rxval_s_r;
   logic [1:0] txstb_s_r;
   logic [1:0] macrdy_s_r;
   logic [1:0] txsr_s_r;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pinit_s_r <= 2'h0;
         lock_s_r <= 2'h0;
         rxval_s_r <= 2'h0;
         txstb_s_r <= 2'h0;
         macrdy_s_r <= 2'h0;
         txsr_s_r <= 2'h3;
      end else begin
         pinit_s_r <= {pinit_s_r[0], power_init_done};
         lock_s_r <= {lock_s_r[0], pll_lock};
         rxval_s_r <= {rxval_s_r[0], lane_receive_valid};
         txstb_s_r <= {txstb_s_r[0], lane_transmit_clock_stable};
         macrdy_s_r <= {macrdy_s_r[0], mac_rx_ready};
         txsr_s_r <= {txsr_s_r[0], mac_transmit_sync_reset};
      end
   end

   // power-on, boot and initialization are complete once power_init_done rises
   wire logic pinit = pinit_s_r[1];
   wire logic base_rel = pinit && lock_s_r[1];
   wire logic ctrl_rel = base_rel && macrdy_s_r[1];
   wire logic rx_rel = base_rel && rxval_s_r[1];
   wire logic tx_rel = pinit && txstb_s_r[1];
   wire logic pcs_rel = !txsr_s_r[1];

   logic mac_rx_reset_b_r;
   logic mac_tx_reset_b_r;
   logic pcs_reset_n_r;
   logic ctrl_reset_b_r;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mac_rx_reset_b_r <= 1'b0;
         mac_tx_reset_b_r <= 1'b0;
         pcs_reset_n_r <= 1'b0;
         ctrl_reset_b_r <= 1'b0;
      end else begin
         mac_rx_reset_b_r <= rx_rel;
         mac_tx_reset_b_r <= tx_rel;
         pcs_reset_n_r <= pcs_rel;
         ctrl_reset_b_r <= ctrl_rel;
      end
   end
   assign mac_rx_reset_b = mac_rx_reset_b_r;
   assign mac_tx_reset_b = mac_tx_reset_b_r;
   assign lane_pcs_async_reset_n = pcs_reset_n_r;
   assign ctrl_reset_b = ctrl_reset_b_r;
   // everything below uses the same sys_clk; local reset is synchronous
   wire logic loc_rst_b = rst_b && ctrl_reset_b_r;

   // static mac and lane configuration
   logic mac_mode_baser_r;
   logic [7:0] mac_core_width_r;
   logic mac_pause_en_r;
   logic [8:0] mac_fifo_depth_r;
   logic lane_mode_r;
   logic lane_scr_r;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mac_mode_baser_r <= 1'b1;
         mac_core_width_r <= 8'(MLRC_CORE_WIDTH);
         mac_pause_en_r <= MLRC_PAUSE_EN;
         mac_fifo_depth_r <= 9'(MLRC_MAC_FIFO_DEPTH);
         lane_mode_r <= MLRC_LANE_64B66B;
         lane_scr_r <= MLRC_LANE_SCRAMBLE;
      end else begin
         mac_mode_baser_r <= mac_mode_baser_r;
         mac_core_width_r <= mac_core_width_r;
         mac_pause_en_r <= mac_pause_en_r;
         mac_fifo_depth_r <= mac_fifo_depth_r;
         lane_mode_r <= lane_mode_r;
         lane_scr_r <= lane_scr_r;
      end
   end
   assign mac_mode_baser = mac_mode_baser_r;
   assign mac_core_width = mac_core_width_r;
   assign mac_pause_en = mac_pause_en_r;
   assign mac_fifo_depth = mac_fifo_depth_r;
   assign lane_mode_64b66b = lane_mode_r;
   assign lane_scramble_en = lane_scr_r;

   // configuration writer: single apb master, two writes, then idle
   mlrc_cfg_state_type state_r;
   mlrc_cfg_state_type state_nxt;
   mlrc_apb_req_type apb_r;
   mlrc_apb_req_type apb_nxt;
   logic cfg_error_r;
   logic cfg_error_nxt;
   logic cfg_done_r;

   always_comb begin
      state_nxt = state_r;
      apb_nxt = apb_r;
      cfg_error_nxt = cfg_error_r;
      case (state_r)
         ST_WAIT: begin
            if (macrdy_s_r[1]) begin
               state_nxt = ST_TX_SETUP;
               apb_nxt.paddr = MLRC_MAC_TX_CFG_ADDR;
               apb_nxt.pwdata = MLRC_TX_CFG_VALUE;
               apb_nxt.psel = 1'b1;
               apb_nxt.pwrite = 1'b1;
               apb_nxt.penable = 1'b0;
            end
         end
         ST_TX_SETUP: begin
            state_nxt = ST_TX_ACCESS;
            apb_nxt.penable = 1'b1;
         end
         ST_TX_ACCESS: begin
            if (pready) begin
               cfg_error_nxt = cfg_error_r || pslverr;
               state_nxt = ST_RX_SETUP;
               apb_nxt.paddr = MLRC_MAC_RX_CFG_ADDR;
               apb_nxt.pwdata = MLRC_RX_CFG_VALUE;
               apb_nxt.penable = 1'b0;
            end
         end
         ST_RX_SETUP: begin
            state_nxt = ST_RX_ACCESS;
            apb_nxt.penable = 1'b1;
         end
         ST_RX_ACCESS: begin
            if (pready) begin
               cfg_error_nxt = cfg_error_r || pslverr;
               state_nxt = ST_DONE;
               apb_nxt = '0;
            end
         end
         ST_DONE: begin
            state_nxt = ST_DONE;
         end
         default: begin
            state_nxt = ST_WAIT;
            apb_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!loc_rst_b) begin
         state_r <= ST_WAIT;
         apb_r <= '0;
         cfg_error_r <= 1'b0;
         cfg_done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         apb_r <= apb_nxt;
         cfg_error_r <= cfg_error_nxt;
         cfg_done_r <= (state_nxt == ST_DONE);
      end
   end
   assign paddr = apb_r.paddr;
   assign psel = apb_r.psel;
   assign penable = apb_r.penable;
   assign pwrite = apb_r.pwrite;
   assign pwdata = apb_r.pwdata;
   assign cfg_done = cfg_done_r;
   assign cfg_error = cfg_error_r;

   // completed transfers since controller release, saturating
   logic [1:0] xfer_cnt_r;
   wire logic xfer_end = psel && penable && pready;
   always_ff @(posedge sys_clk) begin
      if (!loc_rst_b) begin
         xfer_cnt_r <= 2'h0;
      end else if (xfer_end && xfer_cnt_r != 2'h3) begin
         xfer_cnt_r <= xfer_cnt_r + 2'h1;
      end
   end

   // loopback: receive beats through the fifo to transmit
   mlrc_beat_type rx_beat;
   mlrc_beat_type tx_beat;
   assign rx_beat = '{data: rx_data, sop: rx_sop, eop: rx_eop,
                      byte_valid: rx_byte_valid};
   mlrc_fifo #(
      .WIDTH(MLRC_BEAT_W),
      .DEPTH(LOOP_DEPTH)
   ) u_loop_fifo (
      .sys_clk(sys_clk),
      .rst_b(loc_rst_b),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_beat),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_beat)
   );
   assign tx_data = tx_beat.data;
   assign tx_sop = tx_beat.sop;
   assign tx_eop = tx_beat.eop;
   assign tx_byte_valid = tx_beat.byte_valid;

   // clock figures the conditioner is built
   localparam int CFG_DIV_NUM = MLRC_REF_KHZ / MLRC_CFG_KHZ;

   AST_BASE_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !base_rel |=> !ctrl_reset_b && !mac_rx_reset_b)
      else $error("released without power init and lock");
   AST_CTRL_REL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctrl_reset_b |-> $past(ctrl_rel))
      else $error("controller released early");
   AST_RX_REL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(mac_rx_reset_b) |-> $past(base_rel && rxval_s_r[1]))
      else $error("mac rx reset released early");
   AST_TX_REL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      mac_tx_reset_b |-> $past(pinit && txstb_s_r[1]))
      else $error("mac tx reset released early");
   AST_PCS_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $past(txsr_s_r[1]) |-> !lane_pcs_async_reset_n)
      else $error("pcs reset not following mac tx reset");
   AST_CFG_WAIT: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      $rose(psel) |-> $past(macrdy_s_r[1]))
      else $error("programming before rx ready");
   AST_TX_WRITE: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      psel && paddr == MLRC_MAC_TX_CFG_ADDR |-> pwdata[MLRC_TX_EN_BIT]
      && pwdata[MLRC_TX_CRC_INS_BIT] && pwrite)
      else $error("bad transmit config write");
   AST_RX_WRITE: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      psel && paddr == MLRC_MAC_RX_CFG_ADDR |-> pwdata[MLRC_RX_EN_BIT]
      && pwdata[MLRC_RX_CRC_REM_BIT] && pwrite)
      else $error("bad receive config write");
   AST_ONCE: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      cfg_done |=> cfg_done && !psel)
      else $error("configuration changed after done");
   AST_APB_SEQ: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      psel && !penable |=> psel && penable)
      else $error("apb setup not followed by access");
   AST_LOOP_SOP: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      rx_valid && rx_ready && rx_sop && $past(!tx_valid) && !tx_valid
      |-> ##[1:3] tx_valid)
      else $error("frame not looped");
   AST_STATIC: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !mac_pause_en && mac_fifo_depth == 9'(MLRC_MAC_FIFO_DEPTH)
      && mac_core_width == 8'(MLRC_CORE_WIDTH) && CFG_DIV_NUM >= 1)
      else $error("static mac settings wrong");
   AST_TWO_WRITES: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      xfer_cnt_r != 2'h3)
      else $error("more than two configuration writes");
   AST_DONE_COUNT: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      cfg_done |-> xfer_cnt_r == 2'h2)
      else $error("done without both writes");
   AST_ERR_LATCH: assert property (@(posedge sys_clk) disable iff (!loc_rst_b)
      psel && penable && pready && pslverr |=> cfg_error)
      else $error("slave error not latched");
   AST_TX_DROP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !lane_transmit_clock_stable |-> ##[1:3] !mac_tx_reset_b)
      else $error("mac tx reset not reapplied");
   AST_RX_DROP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !lane_receive_valid |-> ##[1:3] !mac_rx_reset_b)
      else $error("mac rx reset not reapplied");
   AST_LOCK_DROP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pll_lock |-> ##[1:3] (!mac_rx_reset_b && !ctrl_reset_b))
      else $error("resets not reapplied without lock");
endmodule : mlrc_top

// File: hw/mlrc_pkg.sv
// package: constants and carrier types for the mac loopback reset/config block
package mlrc_pkg;
   // mac datapath widths and internal fifo depths
   localparam int MLRC_CORE_WIDTH = 32;
   localparam int MLRC_SYS_WIDTH = 64;
   localparam int MLRC_MAC_FIFO_DEPTH = 256;
   localparam int MLRC_LOOP_DEPTH = 16;
   localparam logic MLRC_PAUSE_EN = 1'b0;
   // transceiver lane settings
   localparam int MLRC_LINE_RATE_KBPS = 10312500;
   localparam logic MLRC_LANE_64B66B = 1'b1;
   localparam logic MLRC_LANE_SCRAMBLE = 1'b1;
   // clock conditioner figures
   localparam int MLRC_REF_KHZ = 156250;
   localparam int MLRC_CFG_KHZ = 50000;
   localparam int MLRC_USER_KHZ = 156250;
   // register map of the mac
   localparam logic [7:0] MLRC_MAC_TX_CFG_ADDR = 8'h0A;
   localparam logic [7:0] MLRC_MAC_RX_CFG_ADDR = 8'h0B;
   localparam int MLRC_TX_EN_BIT = 3;
   localparam int MLRC_TX_CRC_INS_BIT = 4;
   localparam int MLRC_RX_CRC_REM_BIT = 0;
   localparam int MLRC_RX_EN_BIT = 3;
   localparam logic [31:0] MLRC_TX_CFG_VALUE = 32'h0000_0018;
   localparam logic [31:0] MLRC_RX_CFG_VALUE = 32'h0000_0009;
   localparam int MLRC_BYTE_COUNT_W = 3;

   typedef struct packed {
      logic [MLRC_SYS_WIDTH-1:0] data;
      logic sop;
      logic eop;
      logic [MLRC_BYTE_COUNT_W-1:0] byte_valid;
   } mlrc_beat_type;

   localparam int MLRC_BEAT_W = $bits(mlrc_beat_type);

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } mlrc_apb_req_type;
endpackage : mlrc_pkg

// File: hw/mlrc_fifo.sv
// loopback fifo with valid/ready on both sides
`timescale 1ns/10ps
module mlrc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic [WIDTH-1:0] out_data_r;
   logic out_valid_r;
   logic in_ready_r;
   wire logic push = in_valid && in_ready;
   wire logic mem_has = (count_r != '0);
   wire logic take = out_valid_r && out_ready;
   wire logic pop = mem_has && (!out_valid_r || take);
   wire logic full = (count_r == (AW + 1)'(DEPTH));
   wire logic [AW:0] count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);

   // ready is registered from the next count so the port comes from a flop
   assign in_ready = in_ready_r;
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
         in_ready_r <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
            out_data_r <= mem_r[rd_ptr_r];
         end
         count_r <= count_nxt;
         in_ready_r <= (count_nxt != (AW + 1)'(DEPTH));
         if (pop) begin
            out_valid_r <= 1'b1;
         end else if (take) begin
            out_valid_r <= 1'b0;
         end
      end
   end

   AST_FIFO_NO_OVER: assert property (@(posedge sys_clk) disable iff (!rst_b)
      full |-> !in_ready)
      else $error("fifo accepts while full");
   AST_FIFO_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("fifo output changed under stall");
endmodule : mlrc_fifo

// File: testbench/mlrc_mac_model.sv
// apb register slave standing in for the mac configuration port
`timescale 1ns/10ps
module mlrc_mac_model
   import mlrc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   // bench controls and observed registers
   input wire logic slow,
   input wire logic err,
   output logic [31:0] tx_cfg_r,
   output logic [31:0] rx_cfg_r,
   output logic [7:0] writes_r
);
   logic wait_r;
   logic hit;
   logic tx_hit;
   logic rx_hit;
   // one wait state per access when slow is set
   assign hit = psel && penable && (wait_r == slow);
   assign tx_hit = hit && pwrite && (paddr == MLRC_MAC_TX_CFG_ADDR);
   assign rx_hit = hit && pwrite && (paddr == MLRC_MAC_RX_CFG_ADDR);
   assign pready = hit;
   assign pslverr = hit && err;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wait_r <= 1'b0;
         tx_cfg_r <= 32'h0;
         rx_cfg_r <= 32'h0;
         writes_r <= 8'h0;
      end else if (psel && penable) begin
         wait_r <= !hit;
         writes_r <= writes_r + {7'h0, hit && pwrite};
         tx_cfg_r <= tx_hit ? pwdata : tx_cfg_r;
         rx_cfg_r <= rx_hit ? pwdata : rx_cfg_r;
      end
   end
endmodule : mlrc_mac_model

// File: testbench/testbench.sv
// self-checking bench for the mac loopback reset and configuration block
`timescale 1ns/10ps
module testbench;
   import mlrc_pkg::*;
   logic sys_clk, rst_b, power_init_done, pll_lock, lane_receive_valid;
   logic lane_transmit_clock_stable, mac_rx_ready, mac_transmit_sync_reset;
   logic mac_rx_reset_b, mac_tx_reset_b, lane_pcs_async_reset_n, ctrl_reset_b;
   logic mac_mode_baser, mac_pause_en, lane_mode_64b66b, lane_scramble_en;
   logic [7:0] mac_core_width, paddr, writes_r;
   logic [8:0] mac_fifo_depth;
   logic psel, penable, pwrite, pready, pslverr, cfg_done, cfg_error, slow, err;
   logic [31:0] pwdata, tx_cfg_r, rx_cfg_r;
   logic rx_valid, rx_sop, rx_eop, rx_ready, tx_valid, tx_sop, tx_eop, tx_ready;
   logic [63:0] rx_data, tx_data;
   logic [2:0] rx_byte_valid, tx_byte_valid;
   int errors, checks;

   mlrc_top #(.SYS_WIDTH(64), .LOOP_DEPTH(16)) u_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .power_init_done(power_init_done),
      .pll_lock(pll_lock), .lane_receive_valid(lane_receive_valid),
      .lane_transmit_clock_stable(lane_transmit_clock_stable), .mac_rx_ready(mac_rx_ready),
      .mac_transmit_sync_reset(mac_transmit_sync_reset), .mac_rx_reset_b(mac_rx_reset_b),
      .mac_tx_reset_b(mac_tx_reset_b), .lane_pcs_async_reset_n(lane_pcs_async_reset_n),
      .ctrl_reset_b(ctrl_reset_b), .mac_mode_baser(mac_mode_baser),
      .mac_core_width(mac_core_width), .mac_pause_en(mac_pause_en),
      .mac_fifo_depth(mac_fifo_depth), .lane_mode_64b66b(lane_mode_64b66b),
      .lane_scramble_en(lane_scramble_en), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .cfg_done(cfg_done), .cfg_error(cfg_error), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_byte_valid(rx_byte_valid), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop),
      .tx_byte_valid(tx_byte_valid), .tx_ready(tx_ready)
   );
   mlrc_mac_model u_mac (
      .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .slow(slow),
      .err(err), .tx_cfg_r(tx_cfg_r), .rx_cfg_r(rx_cfg_r), .writes_r(writes_r)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : hold

   // bounded wait on a status output, ends the run on expiry
   task automatic wait_for(input int sel, input int lim);
      int k;
      for (k = 0; k <= lim; k++) begin
         if ((sel == 0 && mac_tx_reset_b === 1'b1) || (sel == 1 && mac_rx_reset_b === 1'b1)
             || (sel == 2 && cfg_done === 1'b1)) begin
            return;
         end
         @(negedge sys_clk);
      end
      errors++;
      $display("BAD %0t wait %0d expired", $time, sel);
      wrap_up();
   endtask : wait_for

   function automatic mlrc_beat_type mk_beat(input int i);
      mk_beat.data = {32'hC0DE_0000 + 32'(i), 32'h1234_5678 ^ 32'(i)};
      mk_beat.sop = (i % 5 == 0);
      mk_beat.eop = (i % 5 == 4);
      mk_beat.byte_valid = 3'(i);
   endfunction : mk_beat

   task automatic t_reset;
      chk({mac_rx_reset_b, mac_tx_reset_b, ctrl_reset_b}, 72'h0, "resets held");
      chk({mac_mode_baser, mac_core_width}, {1'b1, 8'h20}, "core mode");
      chk({mac_pause_en, mac_fifo_depth}, {1'b0, 9'h100}, "pause fifo");
      chk({lane_mode_64b66b, lane_scramble_en}, 72'h3, "lane coding");
      power_init_done = 1'b1;
      lane_transmit_clock_stable = 1'b1;
      wait_for(0, 10);
      hold(5);
      chk({mac_rx_reset_b, ctrl_reset_b}, 72'h0, "no lock yet");
      lane_transmit_clock_stable = 1'b0;
      hold(5);
      chk(mac_tx_reset_b, 1'b0, "tx reset back");
      lane_transmit_clock_stable = 1'b1;
      lane_receive_valid = 1'b1;
      hold(5);
      chk(mac_rx_reset_b, 1'b0, "rx waits lock");
      pll_lock = 1'b1;
      wait_for(1, 10);
      hold(5);
      chk(ctrl_reset_b, 1'b0, "ctrl waits ready");
      chk(writes_r, 8'h0, "no early writes");
      mac_transmit_sync_reset = 1'b1;
      hold(5);
      chk(lane_pcs_async_reset_n, 1'b0, "pcs reset on");
      mac_transmit_sync_reset = 1'b0;
      hold(5);
      chk(lane_pcs_async_reset_n, 1'b1, "pcs reset off");
      $display("test reset sequencing finished");
   endtask : t_reset

   task automatic t_config;
      slow = 1'b1;
      mac_rx_ready = 1'b1;
      wait_for(2, 60);
      chk(ctrl_reset_b, 1'b1, "ctrl released");
      chk(tx_cfg_r, 32'h18, "tx config");
      chk(rx_cfg_r, 32'h09, "rx config");
      chk({cfg_error, writes_r}, {1'b0, 8'h02}, "write count");
      hold(30);
      chk({psel, writes_r}, {1'b0, 8'h02}, "no later writes");
      $display("test configuration finished");
   endtask : t_config

   task automatic t_loop;
      int k;
      int n;
      int m;
      n = 0;
      tx_ready = 1'b0;
      for (k = 0; k < 40; k++) begin
         @(negedge sys_clk);
         if (rx_ready !== 1'b1) break;
         {rx_data, rx_sop, rx_eop, rx_byte_valid} = mk_beat(n);
         rx_valid = 1'b1;
         n++;
      end
      rx_valid = 1'b0;
      chk(n >= 16, 1'b1, "fifo holds 16");
      hold(3);
      chk(rx_ready, 1'b0, "full refuses");
      m = 0;
      for (k = 0; k < 200 && m < n; k++) begin
         @(negedge sys_clk);
         tx_ready = k[0];
         if (k[0] && tx_valid === 1'b1) begin
            chk({tx_data, tx_sop, tx_eop, tx_byte_valid}, mk_beat(m), "beat");
            m++;
         end
      end
      chk(m, n, "all beats looped");
      hold(3);
      chk({tx_valid, rx_ready}, 72'h1, "drained");
      $display("test loopback finished");
   endtask : t_loop

   task automatic t_error;
      rst_b = 1'b0;
      err = 1'b1;
      slow = 1'b0;
      hold(3);
      chk({cfg_done, cfg_error, psel}, 72'h0, "reset clears");
      rst_b = 1'b1;
      wait_for(2, 60);
      chk({cfg_error, writes_r}, {1'b1, 8'h02}, "error latched");
      $display("test slave error finished");
   endtask : t_error

   initial begin
      errors = 0;
      checks = 0;
      rst_b = 1'b0;
      {power_init_done, pll_lock, lane_receive_valid, lane_transmit_clock_stable} = 4'h0;
      {mac_rx_ready, mac_transmit_sync_reset, slow, err} = 4'h0;
      {rx_valid, rx_sop, rx_eop, rx_byte_valid, tx_ready} = 7'h0;
      rx_data = 64'h0;
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      hold(2);
      t_reset();
      t_config();
      t_loop();
      t_error();
      wrap_up();
   end
endmodule : testbench
